/* File: esb_cond_block.v */
`timescale 1ns/100ps
`include "esb_regs.vh"
module esb_cond_block (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_n_sync,
  // block control
  input  wire       blk_start,
  input  wire [3:0] blk_cond,
  input  wire [3:0] blk_mask,
  input  wire       blk_step,
  input  wire       blk_clear,
  input  wire       blk_load,
  input  wire [7:0] blk_load_val,
  // state out
  output wire [7:0] blk_state,
  output wire       blk_active,
  output wire [3:0] blk_cur_cond
);
  reg  [7:0] state_reg;
  reg  [7:0] state_next;
  // state: [7:4] base condition, [3:0] mask; 4 mask bits cap at four
  always @* begin
    state_next = state_reg;
    if (blk_clear) begin
      state_next = `ESB_STATE_RESET;
    end else if (blk_load) begin
      state_next = blk_load_val;
    end else if (blk_start) begin
      state_next = {blk_cond, blk_mask};
    end else if (blk_step && blk_active) begin
      if (state_reg[2:0] == 3'h0) begin
        state_next = `ESB_STATE_RESET;
      end else begin
        // shift mask; low cond bit follows mask top: same or inverse
        state_next = {state_reg[7:5], state_reg[3],
                      state_reg[2:0], 1'b0};
      end
    end
  end
  always @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg <= `ESB_STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end
  assign blk_state    = state_reg;
  assign blk_active   = (state_reg[3:0] != 4'h0);
  assign blk_cur_cond = state_reg[7:4];
endmodule

/* File: esb_exec_state.v */
`timescale 1ns/100ps
`include "esb_regs.vh"
// Contract
// - One split field in bits 26:25 and 15:10 holds either transfer resume or conditional block state.
// - While resume state is held, bits 26:25 and 11:10 read as zero.
// - An interrupt during a multi-register transfer saves the next register number in bits 15:12.
// - After servicing, the transfer resumes at the register saved in bits 15:12.
// - A conditional block covers at most four following instructions, tracked in the split field.
// - Each instruction in a block uses one shared condition or its inverse.
// - Bit 24 is the instruction-set state, resets to one and normally stays set.
// - Register branch-exchange, branch-link-exchange and pop into pc load bit 24.
// - Exception return reloads bit 24 from the stacked status word.
// - Exception entry or reset loads bit 24 from bit 0 of the fetched vector.
// - Executing with bit 24 clear raises a fault or lockup instead.
// - Bits 23:16 and 9:7 are read-only reserved and read zero.
// - The split field and bit 24 are meaningful only in the full or execution views.
// - Software status-move reads of these bits return zero and writes are ignored.
// - At reset bit 0 of the vector from address 0x0000_0004 loads bit 24.
module esb_exec_state (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // multi-register transfer
  input  wire        mt_irq_suspend,
  input  wire [3:0]  mt_next_reg,
  input  wire        mt_resume,
  input  wire        mt_done,
  output reg  [3:0]  mt_resume_reg,
  output wire        mt_resume_valid,
  // conditional block
  input  wire        blk_start,
  input  wire [3:0]  blk_cond,
  input  wire [3:0]  blk_mask,
  input  wire        blk_step,
  output wire        blk_active,
  output wire [3:0]  blk_cur_cond,
  // instruction-set state sources
  input  wire        br_exchange,
  input  wire        br_link_exchange,
  input  wire        pop_into_pc,
  input  wire [31:0] br_target,
  input  wire        exc_return,
  input  wire [31:0] stacked_status,
  input  wire        vector_load,
  input  wire        reset_vector_load,
  input  wire [31:0] vector_value,
  // execution check
  input  wire        instr_issue,
  output reg         isa_fault,
  // status views
  input  wire [1:0]  view_sel,
  input  wire        sw_write,
  input  wire [31:0] sw_wdata,
  output reg  [31:0] status_view,
  output wire [31:0] vector_fetch_addr,
  output wire        isa_state
);
  reg  [1:0]  rst_sync_reg;
  wire        rst_n_sync;
  reg         isa_reg;
  reg         isa_next;
  reg  [3:0]  resume_reg;
  reg  [3:0]  resume_next;
  reg         resume_valid_reg;
  reg         resume_valid_next;
  reg  [31:0] view_next;
  wire [7:0]  blk_state;
  wire        load_blk;
  wire [31:0] exec_bits;
  wire        stacked_is_blk;
  wire [1:0]  stacked_hi;
  wire [1:0]  stacked_lo;
  wire [3:0]  stacked_reg;
  wire [7:0]  stacked_blk_val;
  wire        stacked_resume_ok;
  wire        branch_src;
  wire        vector_src;
  wire [1:0]  blk_mask_hi;
  wire [1:0]  blk_mask_lo;
  wire [3:0]  blk_cond_bits;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_reg[1];

  // stacked word fields
  assign stacked_hi  = stacked_status[`ESB_HI_MSB:`ESB_HI_LSB];
  assign stacked_lo  = stacked_status[`ESB_BLK_LO_MSB:`ESB_BLK_LO_LSB];
  assign stacked_reg = stacked_status[`ESB_REG_MSB:`ESB_REG_LSB];
  // stacked word decoded as block state when its block-only bits are set
  assign stacked_is_blk =
    (stacked_hi != 2'b00) || (stacked_lo != 2'b00);
  assign stacked_resume_ok =
    !stacked_is_blk && (stacked_reg != 4'h0);
  assign stacked_blk_val = {stacked_reg, stacked_hi, stacked_lo};
  assign load_blk        = exc_return && stacked_is_blk;
  assign vector_src      = vector_load || reset_vector_load;
  assign branch_src      = br_exchange || br_link_exchange || pop_into_pc;

  esb_cond_block u_blk (
    .ref_clk      (ref_clk),
    .rst_n_sync   (rst_n_sync),
    .blk_start    (blk_start),
    .blk_cond     (blk_cond),
    .blk_mask     (blk_mask),
    .blk_step     (blk_step),
    .blk_clear    (mt_irq_suspend),
    .blk_load     (load_blk),
    .blk_load_val (stacked_blk_val),
    .blk_state    (blk_state),
    .blk_active   (blk_active),
    .blk_cur_cond (blk_cur_cond)
  );

  // instruction-set state
  always @* begin
    isa_next = isa_reg;
    if (vector_src) begin
      isa_next = vector_value[0];
    end else if (exc_return) begin
      isa_next = stacked_status[`ESB_ISA_BIT];
    end else if (branch_src) begin
      isa_next = br_target[0];
    end
  end

  // multi-register resume state
  always @* begin
    resume_next       = resume_reg;
    resume_valid_next = resume_valid_reg;
    if (mt_irq_suspend) begin
      resume_next       = mt_next_reg;
      resume_valid_next = 1'b1;
    end else if (exc_return) begin
      resume_next       = stacked_reg;
      resume_valid_next = stacked_resume_ok;
    end else if (mt_done || blk_start) begin
      resume_next       = 4'h0;
      resume_valid_next = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      isa_reg <= `ESB_ISA_RESET;
    end else begin
      isa_reg <= isa_next;
    end
  end

  always @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      resume_reg       <= 4'h0;
      resume_valid_reg <= 1'b0;
    end else begin
      resume_reg       <= resume_next;
      resume_valid_reg <= resume_valid_next;
    end
  end

  // restart register only moves while resume state is held
  always @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      mt_resume_reg <= 4'h0;
    end else if (mt_resume && resume_valid_reg) begin
      mt_resume_reg <= resume_reg;
    end
  end

  always @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      isa_fault <= 1'b0;
    end else begin
      isa_fault <= instr_issue && !isa_reg;
    end
  end

  assign mt_resume_valid   = resume_valid_reg;
  assign isa_state         = isa_reg;
  assign vector_fetch_addr = `ESB_RESET_VECTOR_ADDR;

  // block state fields
  assign blk_cond_bits = blk_state[7:4];
  assign blk_mask_hi   = blk_state[3:2];
  assign blk_mask_lo   = blk_state[1:0];

  // split field assembly; resume state forces block-only bits to zero
  assign exec_bits[`ESB_FLAG_MSB:`ESB_FLAG_LSB] = 5'h00;
  assign exec_bits[`ESB_HI_MSB:`ESB_HI_LSB] =
    resume_valid_reg ? 2'b00 : blk_mask_hi;
  assign exec_bits[`ESB_ISA_BIT] = isa_reg;
  assign exec_bits[`ESB_RSV_HI_MSB:`ESB_RSV_HI_LSB] = 8'h00;
  assign exec_bits[`ESB_REG_MSB:`ESB_REG_LSB] =
    resume_valid_reg ? resume_reg : blk_cond_bits;
  assign exec_bits[`ESB_BLK_LO_MSB:`ESB_BLK_LO_LSB] =
    resume_valid_reg ? 2'b00 : blk_mask_lo;
  assign exec_bits[`ESB_RSV_LO_MSB:`ESB_RSV_LO_LSB] = 3'h0;
  assign exec_bits[`ESB_EXC_MSB:`ESB_EXC_LSB] = 7'h00;

  // views; sw_write/sw_wdata have no effect on these bits
  always @* begin
    view_next = `ESB_WORD_ZERO;
    if (view_sel == `ESB_VIEW_FULL) begin
      view_next = exec_bits;
    end else if (view_sel == `ESB_VIEW_EXEC) begin
      view_next = exec_bits;
    end else begin
      view_next = `ESB_WORD_ZERO;
    end
  end

  always @(posedge ref_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      status_view <= `ESB_WORD_ZERO;
    end else begin
      status_view <= view_next;
    end
  end
endmodule

/* File: esb_exec_state_sva.sv */
`timescale 1ns/100ps
module esb_exec_state_sva (
  // clock and reset
  input logic        ref_clk, rst_b,
  // control and state
  input logic        mt_irq_suspend, blk_start, blk_active, instr_issue,
  input logic        br_exchange, br_link_exchange, pop_into_pc, exc_return,
  input logic        vector_load, reset_vector_load, isa_fault, isa_state,
  input logic [3:0]  mt_next_reg, blk_mask,
  input logic [1:0]  view_sel,
  input logic [31:0] br_target, stacked_status, vector_value, status_view,
  input logic [31:0] vector_fetch_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire vec = vector_load | reset_vector_load;
  wire brx = br_exchange | br_link_exchange | pop_into_pc;
  a_rsv_zero: assert property (
    status_view[23:16] == 8'h00 && status_view[9:7] == 3'h0)
    else $error("reserved bits nonzero");
  a_view_hidden: assert property (
    view_sel[1] |=> status_view == 32'h0000_0000) else $error("view leak");
  a_fault_cause: assert property (
    isa_fault == $past(instr_issue && !isa_state)) else $error("fault");
  a_vec_isa: assert property (
    vec |=> isa_state == $past(vector_value[0])) else $error("vector isa");
  a_ret_isa: assert property (
    exc_return && !vec |=> isa_state == $past(stacked_status[24]))
    else $error("return isa");
  a_br_isa: assert property (
    brx && !exc_return && !vec |=> isa_state == $past(br_target[0]))
    else $error("branch isa");
  a_isa_hold: assert property (
    !brx && !exc_return && !vec |=> $stable(isa_state)) else $error("isa");
  a_suspend_save: assert property (
    mt_irq_suspend ##1 view_sel == 2'h0 |=>
    {status_view[26:25], status_view[15:10]} ==
    {2'b00, $past(mt_next_reg, 2), 2'b00})
    else $error("resume field");
  a_blk_start: assert property (
    blk_start && blk_mask != 4'h0 && !mt_irq_suspend && !exc_return
    |=> blk_active) else $error("block start");
  a_vec_addr: assert property (
    vector_fetch_addr == 32'h0000_0004) else $error("vector address");
endmodule

/* File: esb_regs.vh */
`ifndef ESB_REGS_VH
`define ESB_REGS_VH
// execution-state field positions within the combined status word
`define ESB_HI_MSB        26
`define ESB_HI_LSB        25
`define ESB_ISA_BIT       24
`define ESB_RSV_HI_MSB    23
`define ESB_RSV_HI_LSB    16
`define ESB_LO_MSB        15
`define ESB_LO_LSB        10
`define ESB_REG_MSB       15
`define ESB_REG_LSB       12
`define ESB_RSV_LO_MSB    9
`define ESB_RSV_LO_LSB    7
`define ESB_BLK_LO_MSB    11
`define ESB_BLK_LO_LSB    10
`define ESB_FLAG_MSB      31
`define ESB_FLAG_LSB      27
`define ESB_EXC_MSB       6
`define ESB_EXC_LSB       0
// reset values
`define ESB_ISA_RESET     1'b1
`define ESB_STATE_RESET   8'h00
`define ESB_WORD_ZERO     32'h0000_0000
// vector fetched at reset
`define ESB_RESET_VECTOR_ADDR 32'h0000_0004
// view select codes
`define ESB_VIEW_FULL     2'h0
`define ESB_VIEW_EXEC     2'h1
`define ESB_VIEW_OTHER    2'h2
`define ESB_VIEW_SWREAD   2'h3
// conditional block limits
`define ESB_BLOCK_MAX     3'h4
`endif

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
  reg         ref_clk = 0, rst_b = 0, e;
  reg  [3:0]  nr, cd, mk;
  reg  [31:0] v;
  integer     err_count = 0, n_tests = 0, seed = 61, i, k, s;
  reg  [3:0]  mt_next_reg = 0, blk_cond = 0, blk_mask = 0;
  reg  [1:0]  view_sel = 0;
  reg         mt_irq_suspend = 0, mt_resume = 0, mt_done = 0, blk_start = 0;
  reg         blk_step = 0, br_exchange = 0, br_link_exchange = 0;
  reg         pop_into_pc = 0, exc_return = 0, vector_load = 0;
  reg         reset_vector_load = 0, instr_issue = 0, sw_write = 0;
  reg  [31:0] br_target = 0, stacked_status = 0, vector_value = 0;
  reg  [31:0] sw_wdata = 0;
  wire [31:0] status_view, vector_fetch_addr;
  wire [3:0]  mt_resume_reg, blk_cur_cond;
  wire        mt_resume_valid, blk_active, isa_fault, isa_state;
  esb_exec_state dut_u (
    .ref_clk           (ref_clk),
    .rst_b             (rst_b),
    .mt_irq_suspend    (mt_irq_suspend),
    .mt_next_reg       (mt_next_reg),
    .mt_resume         (mt_resume),
    .mt_done           (mt_done),
    .mt_resume_reg     (mt_resume_reg),
    .mt_resume_valid   (mt_resume_valid),
    .blk_start         (blk_start),
    .blk_cond          (blk_cond),
    .blk_mask          (blk_mask),
    .blk_step          (blk_step),
    .blk_active        (blk_active),
    .blk_cur_cond      (blk_cur_cond),
    .br_exchange       (br_exchange),
    .br_link_exchange  (br_link_exchange),
    .pop_into_pc       (pop_into_pc),
    .br_target         (br_target),
    .exc_return        (exc_return),
    .stacked_status    (stacked_status),
    .vector_load       (vector_load),
    .reset_vector_load (reset_vector_load),
    .vector_value      (vector_value),
    .instr_issue       (instr_issue),
    .isa_fault         (isa_fault),
    .view_sel          (view_sel),
    .sw_write          (sw_write),
    .sw_wdata          (sw_wdata),
    .status_view       (status_view),
    .vector_fetch_addr (vector_fetch_addr),
    .isa_state         (isa_state)
  );
  always #4 ref_clk = ~ref_clk;
  task cyc(input integer n); repeat (n) @(posedge ref_clk); #1; endtask
  task chk(input [31:0] seen, exp, input string nm);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // instructions in a block from the terminator position
  function integer blen(input [3:0] m);
    blen = m[0] ? 4 : m[1] ? 3 : m[2] ? 2 : 1;
  endfunction
  initial begin
    #100000;
    err_count = err_count + 1;
    stop_test;
  end
  initial begin
    cyc(20);
    rst_b = 1;
    cyc(3);
    chk(isa_state, 1, "isa_rst");
    chk(status_view, 32'h0100_0000, "word_rst");
    for (i = 0; i < 40; i = i + 1) begin
      v = $random(seed);
      s = v[6:4] % 6;
      br_target = v; stacked_status = v; vector_value = v;
      {pop_into_pc, br_link_exchange, br_exchange, exc_return,
       reset_vector_load, vector_load} = 6'h01 << s;
      e = s == 2 ? v[24] : v[0];
      cyc(1);
      {pop_into_pc, br_link_exchange, br_exchange, exc_return} = 4'h0;
      {reset_vector_load, vector_load, instr_issue} = 3'h1;
      chk(isa_state, e, "isa");
      cyc(1);
      instr_issue = 0;
      chk(isa_fault, !e, "fault");
    end
    vector_value = 1; reset_vector_load = 1; cyc(1); reset_vector_load = 0;
    chk(isa_state, 1, "isa_vec");
    chk(vector_fetch_addr, 32'h0000_0004, "vaddr");
    for (i = 0; i < 8; i = i + 1) begin
      nr = (i == 0) ? 4'hf : $random(seed);
      mt_next_reg = nr; mt_irq_suspend = 1; view_sel = i[1:0];
      sw_write = 1; sw_wdata = $random(seed);
      cyc(1); mt_irq_suspend = 0;
      chk(mt_resume_valid, 1, "rvalid");
      cyc(1);
      v = view_sel[1] ? 0 : {7'h00, 1'b1, 8'h00, nr, 12'h000};
      chk(status_view, v, "rword");
      mt_resume = 1; cyc(1); mt_resume = 0;
      chk(mt_resume_reg, nr, "rreg");
      mt_done = 1; cyc(1); mt_done = 0;
      chk(mt_resume_valid, 0, "rdone");
    end
    view_sel = 0; sw_write = 0;
    for (i = 0; i < 8; i = i + 1) begin
      cd = $random(seed); mk = $random(seed);
      mk = (i == 0) ? 4'h1 : (i == 1 || mk == 0) ? 4'h8 : mk;
      blk_cond = cd; blk_mask = mk; blk_start = 1; cyc(1); blk_start = 0;
      cyc(1);
      v = {5'h00, mk[3:2], 9'h100, cd, mk[1:0], 10'h000};
      chk(status_view, v, "bword");
      for (k = 0; k < blen(mk); k = k + 1) begin
        chk(blk_active, 1, "bact");
        chk(blk_cur_cond[3:1], cd[3:1], "bcond");
        chk(blk_cur_cond[0], (k == 0) ? cd[0] : mk[4-k], "bcond0");
        blk_step = 1; cyc(1); blk_step = 0;
      end
      chk(blk_active, 0, "bend");
    end
    stop_test;
  end
endmodule
bind esb_exec_state esb_exec_state_sva chk_u (
  .ref_clk           (ref_clk),
  .rst_b             (rst_b),
  .mt_irq_suspend    (mt_irq_suspend),
  .blk_start         (blk_start),
  .blk_active        (blk_active),
  .instr_issue       (instr_issue),
  .br_exchange       (br_exchange),
  .br_link_exchange  (br_link_exchange),
  .pop_into_pc       (pop_into_pc),
  .exc_return        (exc_return),
  .vector_load       (vector_load),
  .reset_vector_load (reset_vector_load),
  .isa_fault         (isa_fault),
  .isa_state         (isa_state),
  .mt_next_reg       (mt_next_reg),
  .blk_mask          (blk_mask),
  .view_sel          (view_sel),
  .br_target         (br_target),
  .stacked_status    (stacked_status),
  .vector_value      (vector_value),
  .status_view       (status_view),
  .vector_fetch_addr (vector_fetch_addr)
);
